/* File: design/sfspi_pkg.sv */
package sfspi_pkg;

	// System clock
	localparam int CLK_HZ = 25_000_000;

	// Array geometry
	localparam int ADDR_W   = 20;
	localparam int PAGE_W   = 8;
	localparam int SECT_W   = 12;
	localparam int BLK_W    = 16;
	localparam int CMD_ADDR_BYTES = 3;

	// Serial instruction codes
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_PP   = 8'h02;
	localparam logic [7:0] OP_SE   = 8'h20;
	localparam logic [7:0] OP_BE   = 8'hD8;
	localparam logic [7:0] OP_CE   = 8'hC7;

	// Status byte fields
	localparam int SR_WIP   = 0;
	localparam int SR_WEL   = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_SRP   = 7;
	localparam logic [7:0] SR_RESET = 8'h00;

	// Wishbone register offsets and fields
	localparam logic [7:0] WB_STATUS = 8'h00;
	localparam logic [7:0] WB_CTRL   = 8'h04;
	localparam logic [7:0] WB_ADDR   = 8'h08;
	localparam int WBS_ARMED = 8;
	localparam int WBS_WP    = 9;
	localparam int CTRL_LOCK = 0;

	// Internal cycle times and their cycle counts
	localparam real T_PP_MS = 1.5;
	localparam real T_SE_MS = 150.0;
	localparam real T_BE_MS = 800.0;
	localparam real T_CE_S  = 10.0;
	localparam real T_W_MS  = 10.0;
	localparam int unsigned PP_CYC = int'($floor(T_PP_MS * CLK_HZ / 1000.0));
	localparam int unsigned SE_CYC = int'($floor(T_SE_MS * CLK_HZ / 1000.0));
	localparam int unsigned BE_CYC = int'($floor(T_BE_MS * CLK_HZ / 1000.0));
	localparam int unsigned CE_CYC = int'($floor(T_CE_S * CLK_HZ));
	localparam int unsigned W_CYC  = int'($floor(T_W_MS * CLK_HZ / 1000.0));

	// Serial protocol phase
	typedef enum logic [2:0] {
		SF_CMD,
		SF_ADDR,
		SF_READ,
		SF_RDSR,
		SF_PP,
		SF_WRSR,
		SF_SKIP
	} sfspi_state_e;

	// Block protected by the block-protect field
	function automatic logic prot_hit(input logic [2:0] bp, input logic [3:0] blk);
		case (bp)
			3'h0:    prot_hit = 1'b0;
			3'h1:    prot_hit = (blk == 4'hF);
			3'h2:    prot_hit = (blk >= 4'hE);
			3'h3:    prot_hit = (blk >= 4'hC);
			3'h4:    prot_hit = (blk >= 4'h8);
			default: prot_hit = 1'b1;
		endcase
	endfunction

endpackage

/* File: design/sfspi_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module sfspi_mem #(
	parameter int AW = 20,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          clk_i,
	// Single port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Read-first port, registered read data
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end

endmodule
`default_nettype wire

/* File: design/sfspi_top.sv */
// Contract
// - Input bits sampled on serial clock rise
// - Output bit changes on serial clock fall
// - Deselected means output undriven
// - Internal cycle runs on after deselect
// - Low select enables instructions and reads
// - No instruction before first select fall
// - Hold pauses transfer, output undriven
// - Write-protect pin blocks status writes while SRP is set
// - Lock bit and protect bits guard array
// - Page program writes 1 to 256 bytes
// - Program clears bits only, page-local
// - Erase by sector, block, chip only
// - 4096 pages of 256 bytes
// - 256 sectors of 4 KiB
// - 16 blocks of 64 KiB
// - Sector n starts at n times 0x1000
// - Cycle times 1.5, 150, 800 ms, 10 s
// - Serial modes 0 and 3 both work
// - Busy bit shown during internal cycle
`timescale 1ns/1ps
`default_nettype none
module sfspi_top import sfspi_pkg::*; #(
	parameter int unsigned PP_CYCLES = PP_CYC,
	parameter int unsigned SE_CYCLES = SE_CYC,
	parameter int unsigned BE_CYCLES = BE_CYC,
	parameter int unsigned CE_CYCLES = CE_CYC,
	parameter int unsigned W_CYCLES  = W_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Serial pins
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        serial_in_i,
	input  wire logic        hold_n_i,
	input  wire logic        wp_n_i,
	output logic             serial_out_o,
	output logic             serial_out_oe_o,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic       sclk_d_r;
	logic       cs_d_r;
	logic       sclk_q, cs_q, si_q, hold_q, wp_q;
	logic       cs_fall, cs_rise, held, rise_e, fall_e;
	logic       sel_r;
	logic       armed_r;

	// Two flops on every pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end else begin
			sync1_r <= {sclk_i, cs_n_i, serial_in_i, hold_n_i, wp_n_i};
			sync2_r <= sync1_r;
		end
	end

	// Delayed copies for edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b0;
		end else begin
			sclk_d_r <= sclk_q;
			cs_d_r   <= cs_q;
		end
	end

	assign {sclk_q, cs_q, si_q, hold_q, wp_q} = sync2_r;
	assign cs_fall = !cs_q && cs_d_r;
	assign cs_rise = cs_q && !cs_d_r;
	assign held    = sel_r && !hold_q;
	assign rise_e  = sel_r && !held && sclk_q && !sclk_d_r;
	assign fall_e  = sel_r && !held && !sclk_q && sclk_d_r;

	// Selection opens only on a seen high-to-low select edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_r   <= 1'b0;
			armed_r <= 1'b0;
		end else if (cs_fall) begin
			sel_r   <= 1'b1;
			armed_r <= 1'b1;
		end else if (cs_rise) begin
			sel_r   <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bit shifter and protocol phases

	logic [2:0]   bitcnt_r;
	logic [7:0]   sh_r;
	logic         byte_done;
	logic [7:0]   byte_val;
	sfspi_state_e state_r;
	logic [7:0]   cmd_r;
	logic [1:0]   abyte_r;
	logic [23:0]  addr_r;
	logic [7:0]   sr_data_r;
	logic [8:0]   dcnt_r;
	logic [2:0]   ocnt_r;
	logic         busy;

	assign byte_done = rise_e && (bitcnt_r == 3'h7);
	assign byte_val  = {sh_r[6:0], si_q};

	// Shift in one bit per rising serial edge
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_fall) begin
			bitcnt_r <= 3'h0;
			sh_r     <= 8'h00;
		end else if (rise_e) begin
			sh_r     <= byte_val;
			bitcnt_r <= bitcnt_r + 3'h1;
		end
	end

	// Instruction, address and data phases
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_fall) begin
			state_r <= SF_CMD;
			cmd_r   <= 8'h00;
			abyte_r <= 2'h0;
			dcnt_r  <= 9'h000;
		end else if (byte_done) begin
			case (state_r)
				SF_CMD: begin
					cmd_r <= byte_val;
					if (busy) begin
						state_r <= (byte_val == OP_RDSR) ? SF_RDSR : SF_SKIP;
					end else begin
						case (byte_val)
							OP_READ, OP_PP, OP_SE, OP_BE: state_r <= SF_ADDR;
							OP_RDSR: state_r <= SF_RDSR;
							OP_WRSR: state_r <= SF_WRSR;
							default: state_r <= SF_SKIP;
						endcase
					end
				end
				SF_ADDR: begin
					abyte_r <= abyte_r + 2'h1;
					if (abyte_r == 2'(CMD_ADDR_BYTES - 1)) begin
						state_r <= (cmd_r == OP_READ) ? SF_READ : (cmd_r == OP_PP) ? SF_PP : SF_SKIP;
					end
				end
				SF_WRSR: state_r <= SF_SKIP;
				SF_PP:   dcnt_r  <= (dcnt_r == 9'h100) ? dcnt_r : dcnt_r + 9'h001;
				default: state_r <= state_r;
			endcase
		end
	end

	// Address and status data bytes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_r    <= 24'h000000;
			sr_data_r <= 8'h00;
		end else if (byte_done && state_r == SF_ADDR) begin
			addr_r    <= {addr_r[15:0], byte_val};
		end else if (byte_done && state_r == SF_WRSR) begin
			sr_data_r <= byte_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write enable, status bits and start of internal cycles

	logic         wel_r;
	logic [2:0]   bp_r;
	logic         srp_r;
	logic         lock_r;
	logic [19:0]  a20;
	logic         prot_a, aligned, go_pp, go_se, go_be, go_ce, go_sr, end_wr;
	logic [7:0]   sr_byte;

	assign a20     = addr_r[ADDR_W-1:0];
	assign prot_a  = lock_r || prot_hit(bp_r, a20[19:16]);
	assign aligned = sel_r && cs_rise && (bitcnt_r == 3'h0) && !busy;
	assign go_pp   = aligned && state_r == SF_PP && dcnt_r != 9'h000 && wel_r;
	assign go_se   = aligned && state_r == SF_SKIP && cmd_r == OP_SE && abyte_r == 2'h3 && wel_r && !prot_a;
	assign go_be   = aligned && state_r == SF_SKIP && cmd_r == OP_BE && abyte_r == 2'h3 && wel_r && !prot_a;
	assign go_ce   = aligned && state_r == SF_SKIP && cmd_r == OP_CE && wel_r && bp_r == 3'h0 && !lock_r;
	assign go_sr   = aligned && state_r == SF_SKIP && cmd_r == OP_WRSR && wel_r && !(srp_r && !wp_q);
	assign end_wr  = aligned && (cmd_r == OP_PP || cmd_r == OP_SE || cmd_r == OP_BE || cmd_r == OP_CE ||
	                 cmd_r == OP_WRSR || cmd_r == OP_WRDI);
	assign sr_byte = {srp_r, 2'b00, bp_r, wel_r, busy};

	// Write-enable latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wel_r <= 1'b0;
		end else if (aligned && state_r == SF_SKIP && cmd_r == OP_WRITE_ENABLE_CMD) begin
			wel_r <= 1'b1;
		end else if (end_wr) begin
			wel_r <= 1'b0;
		end
	end

	// Protection bits, written only when the pin allows
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bp_r  <= SR_RESET[SR_BP_LO +: 3];
			srp_r <= SR_RESET[SR_SRP];
		end else if (go_sr) begin
			bp_r  <= sr_data_r[SR_BP_LO +: 3];
			srp_r <= sr_data_r[SR_SRP];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Internal cycle timer and erase sweep

	logic [31:0]  timer_r;
	logic         sweep_r;
	logic [19:0]  er_addr_r;
	logic [19:0]  er_last_r;

	assign busy = (timer_r != 32'h0) || sweep_r;

	// Cycle timer runs regardless of select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_r <= 32'h0;
		end else if (go_pp) begin
			timer_r <= PP_CYCLES;
		end else if (go_se) begin
			timer_r <= SE_CYCLES;
		end else if (go_be) begin
			timer_r <= BE_CYCLES;
		end else if (go_ce) begin
			timer_r <= CE_CYCLES;
		end else if (go_sr) begin
			timer_r <= W_CYCLES;
		end else if (timer_r != 32'h0) begin
			timer_r <= timer_r - 32'h1;
		end
	end

	// Erase fills a sector, block or whole array with ones
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sweep_r   <= 1'b0;
			er_addr_r <= 20'h00000;
			er_last_r <= 20'h00000;
		end else if (go_se) begin
			sweep_r   <= 1'b1;
			er_addr_r <= {a20[19:SECT_W], 12'h000};
			er_last_r <= {a20[19:SECT_W], 12'hFFF};
		end else if (go_be) begin
			sweep_r   <= 1'b1;
			er_addr_r <= {a20[19:BLK_W], 16'h0000};
			er_last_r <= {a20[19:BLK_W], 16'hFFFF};
		end else if (go_ce) begin
			sweep_r   <= 1'b1;
			er_addr_r <= 20'h00000;
			er_last_r <= 20'hFFFFF;
		end else if (sweep_r) begin
			er_addr_r <= er_addr_r + 20'h00001;
			sweep_r   <= (er_addr_r != er_last_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Array port: erase sweep, program read-modify-write, read fetch

	logic         pp_ok_r, pp_rd_r, pp_wr_r, fetch_r, load_r;
	logic [19:0]  pp_addr_r;
	logic [7:0]   pp_byte_r;
	logic [19:0]  rd_addr_r;
	logic         mem_we;
	logic [19:0]  mem_addr;
	logic [7:0]   mem_wd, mem_rd;

	// Port select
	always_comb begin
		mem_we   = sweep_r || pp_wr_r;
		mem_addr = rd_addr_r;
		mem_wd   = pp_byte_r & mem_rd;
		if (sweep_r) begin
			mem_addr = er_addr_r;
			mem_wd   = 8'hFF;
		end else if (pp_rd_r || pp_wr_r) begin
			mem_addr = pp_addr_r;
		end
	end

	// Program bytes stay inside their page
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pp_ok_r   <= 1'b0;
			pp_rd_r   <= 1'b0;
			pp_wr_r   <= 1'b0;
			pp_addr_r <= 20'h00000;
			pp_byte_r <= 8'h00;
		end else begin
			pp_rd_r <= byte_done && state_r == SF_PP && pp_ok_r && !prot_hit(bp_r, pp_addr_r[19:16]) && !lock_r;
			pp_wr_r <= pp_rd_r;
			if (byte_done && state_r == SF_ADDR && abyte_r == 2'h2) begin
				pp_ok_r   <= wel_r;
				pp_addr_r <= {addr_r[11:0], byte_val};
			end
			if (byte_done && state_r == SF_PP) begin
				pp_byte_r <= byte_val;
			end
			if (pp_wr_r) begin
				pp_addr_r[PAGE_W-1:0] <= pp_addr_r[PAGE_W-1:0] + 8'h01;
			end
		end
	end

	// Read address and fetch strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_addr_r <= 20'h00000;
			fetch_r   <= 1'b0;
			load_r    <= 1'b0;
		end else begin
			load_r  <= fetch_r;
			fetch_r <= (byte_done && state_r == SF_ADDR && abyte_r == 2'h2 && cmd_r == OP_READ) ||
			           (fall_e && state_r == SF_READ && ocnt_r == 3'h7);
			if (byte_done && state_r == SF_ADDR && abyte_r == 2'h2) begin
				rd_addr_r <= {addr_r[11:0], byte_val};
			end else if (load_r) begin
				rd_addr_r <= rd_addr_r + 20'h00001;
			end
		end
	end

	sfspi_mem #(
		.AW (ADDR_W),
		.DW (8)
	) u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (mem_wd),
		.rdata_o (mem_rd)
	);

	////////////////////////////////////////////////////////////////////////////
	// Serial output

	logic [7:0]   out_sh_r;
	logic         so_r, oe_r;
	logic         out_phase;

	assign out_phase = (state_r == SF_READ) || (state_r == SF_RDSR);

	// Output shifter, moved on falling serial edges
	always_ff @(posedge clk_i) begin
		if (rst_i || cs_fall) begin
			out_sh_r <= 8'h00;
			ocnt_r   <= 3'h0;
			so_r     <= 1'b0;
		end else if (byte_done && state_r == SF_CMD && byte_val == OP_RDSR) begin
			out_sh_r <= sr_byte;
		end else if (load_r) begin
			out_sh_r <= mem_rd;
		end else if (fall_e && out_phase) begin
			so_r     <= out_sh_r[7];
			ocnt_r   <= ocnt_r + 3'h1;
			out_sh_r <= (state_r == SF_RDSR && ocnt_r == 3'h7) ? sr_byte : {out_sh_r[6:0], 1'b0};
		end
	end

	// Drive only while selected, not held and sending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= sel_r && !cs_q && hold_q && out_phase;
		end
	end

	assign serial_out_o    = so_r;
	assign serial_out_oe_o = oe_r;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone registers

	logic         wb_req;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Single-wait answer, control write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			lock_r   <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i && wb_adr_i == WB_CTRL && wb_sel_i[0]) begin
				lock_r <= wb_dat_i[CTRL_LOCK];
			end
			case (wb_adr_i)
				WB_STATUS: wb_dat_o <= {22'h0, wp_q, armed_r, sr_byte};
				WB_CTRL:   wb_dat_o <= {31'h0, lock_r};
				WB_ADDR:   wb_dat_o <= {12'h0, a20};
				default:   wb_dat_o <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_rise_only;
		$changed(bitcnt_r) |-> $past(rise_e) || $past(cs_fall);
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("bit count moved off a rising edge");

	property p_fall_only;
		$changed(serial_out_o) |-> $past(fall_e) || $past(cs_fall);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("output moved off a falling edge");

	property p_desel_off;
		cs_q && $past(cs_q) && $past(cs_q, 2) |-> !serial_out_oe_o;
	endproperty
	a_desel_off: assert property (p_desel_off) else $error("output driven while deselected");

	property p_busy_on;
		cs_rise && timer_r > 32'h1 |=> busy && timer_r == $past(timer_r) - 32'h1;
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("internal cycle stopped at deselect");

	property p_unarmed;
		!armed_r |-> state_r == SF_CMD && bitcnt_r == 3'h0 && !wel_r;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("instruction seen before first select");

	sequence s_held2;
		held ##1 held;
	endsequence
	property p_hold;
		s_held2 |-> !serial_out_oe_o && $stable(bitcnt_r);
	endproperty
	a_hold: assert property (p_hold) else $error("activity while held");

	property p_sr_lock;
		srp_r && !wp_q |=> srp_r && $stable(bp_r);
	endproperty
	a_sr_lock: assert property (p_sr_lock) else $error("status written under pin protect");

	property p_prot;
		pp_wr_r |-> !prot_hit(bp_r, mem_addr[19:16]) && !lock_r;
	endproperty
	a_prot: assert property (p_prot) else $error("write into protected block");

	property p_clear_only;
		pp_wr_r |-> (mem_wd & ~mem_rd) == 8'h00 && $past(pp_rd_r);
	endproperty
	a_clear_only: assert property (p_clear_only) else $error("program set a bit");

	property p_pp_time;
		go_pp |=> timer_r == PP_CYCLES && busy;
	endproperty
	a_pp_time: assert property (p_pp_time) else $error("wrong program cycle length");

endmodule
`default_nettype wire

/* File: dv/sfspi_host.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// SPI host model: pins change only just after system clock edges
module sfspi_host (
	// Clock and mode
	input  wire logic clk_i,
	input  wire logic mode3_i,
	// Serial pins
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      si_o,
	output logic      hold_n_o,
	input  wire logic so_i
);
	// Select starts low, so no select fall has been seen yet
	initial begin
		sclk_o = 1'h0;
		cs_n_o = 1'h0;
		si_o = 1'h0;
		hold_n_o = 1'h1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Select with the clock parked at its idle level
	task automatic sel();
		@(posedge clk_i);
		cs_n_o <= 1'h0;
		wt(4);
	endtask
	// Deselect; the released data line shows the inverse of its last value
	task automatic desel();
		@(posedge clk_i);
		sclk_o <= mode3_i;
		wt(4);
		cs_n_o <= 1'h1;
		si_o <= ~si_o;
		wt(8);
	endtask
	// Hold pin level, then let the synchroniser settle
	task automatic hold(input logic v);
		@(posedge clk_i);
		hold_n_o <= v;
		wt(4);
	endtask
	// One byte MSB first: data set at the fall, read bit taken mid high phase
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_i);
			sclk_o <= 1'h0;
			si_o <= d[i];
			wt(4);
			sclk_o <= 1'h1;
			wt(2);
			q[i] = so_i;
			wt(1);
		end
	endtask
endmodule
`default_nettype wire

/* File: dv/sfspi_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module sfspi_top_tb import sfspi_pkg::*;;
	logic        clk_i, rst_i, sclk, cs_n, si, hold_n, wp_n, so, oe, mode3, oe_seen;
	logic        wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]  wb_adr, q, d1, d2;
	logic [31:0] wb_dw, wb_dr, d;
	logic [3:0]  wb_sel;
	logic [19:0] a;
	int          n_mismatch, checked, cyc_cnt;
	integer      seed;

	// Clock
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end

	sfspi_top #(.PP_CYCLES(50), .SE_CYCLES(50), .W_CYCLES(50)) sfspi_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(si), .hold_n_i(hold_n),
		.wp_n_i(wp_n), .serial_out_o(so), .serial_out_oe_o(oe), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dw), .wb_sel_i(wb_sel), .wb_dat_o(wb_dr),
		.wb_ack_o(wb_ack));
	sfspi_host sfspi_host_i (.clk_i(clk_i), .mode3_i(mode3), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
		.hold_n_o(hold_n), .so_i(so));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Counts: checked=%0d mismatches=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Classic Wishbone cycle, held until ack is sampled
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dw <= wd;
		wb_sel <= {3'($random(seed)), 1'h1};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'h1 && n < 100);
		if (n >= 100) n_mismatch++;
		rd = wb_dr;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
	endtask
	// Instruction with three address bytes, select left low
	task automatic opa(input logic [7:0] op, input logic [23:0] x);
		sfspi_host_i.sel();
		sfspi_host_i.xbyte(op, q);
		sfspi_host_i.xbyte(x[23:16], q);
		sfspi_host_i.xbyte(x[15:8], q);
		sfspi_host_i.xbyte(x[7:0], q);
	endtask
	task automatic one(input logic [7:0] op);
		sfspi_host_i.sel();
		sfspi_host_i.xbyte(op, q);
		sfspi_host_i.desel();
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			wb_io(1'h0, WB_STATUS, 32'h0, d);
			n++;
		end while (d[SR_WIP] !== 1'h0 && n < 3000);
		if (n >= 3000) n_mismatch++;
	endtask
	// Status write after write enable, then wait for the write cycle
	task automatic wrsr(input logic [7:0] v);
		one(OP_WRITE_ENABLE_CMD);
		sfspi_host_i.sel();
		sfspi_host_i.xbyte(OP_WRSR, q);
		sfspi_host_i.xbyte(v, q);
		sfspi_host_i.desel();
		wait_idle();
	endtask
	task automatic rd1(input logic [19:0] x, output logic [7:0] r);
		opa(OP_READ, {4'h0, x});
		sfspi_host_i.xbyte(8'hFF, r);
		sfspi_host_i.desel();
	endtask
	task automatic pp(input logic [19:0] x, input logic [7:0] v);
		one(OP_WRITE_ENABLE_CMD);
		opa(OP_PP, {4'h0, x});
		sfspi_host_i.xbyte(v, q);
		sfspi_host_i.desel();
		wait_idle();
	endtask
	function automatic logic [7:0] prog(input logic [7:0] old, input logic [7:0] nw);
		return old & nw;
	endfunction

	// Timeout and output-enable watch
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (oe === 1'h1) oe_seen <= 1'h1;
		if (cyc_cnt == 30000) begin
			n_mismatch++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hA5B50E88;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dw, wb_sel, mode3, oe_seen} = '0;
		cyc_cnt = 0;
		wp_n = 1'h1;
		rst_i = 1'h1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		wp_n <= 1'($random(seed));
		// Traffic before any select fall is ignored
		sfspi_host_i.xbyte(OP_RDSR, q);
		sfspi_host_i.xbyte(8'hFF, q);
		chk(oe_seen, 1'h0);
		wb_io(1'h0, WB_STATUS, 32'h0, d);
		chk(d[8:0], {1'h0, SR_RESET});
		wb_io(1'h0, 8'h0C, 32'h0, d);
		chk(d, 32'h0);
		d1 = 8'($random(seed));
		wb_io(1'h1, WB_CTRL, {24'h0, d1}, d);
		wb_io(1'h0, WB_CTRL, 32'h0, d);
		chk(d[0], d1[0]);
		wb_io(1'h1, WB_CTRL, 32'h0, d);
		sfspi_host_i.desel();
		$display("Test arming done");
		// Status read in both clock modes
		for (int m = 0; m < 2; m++) begin
			mode3 <= 1'(m);
			sfspi_host_i.desel();
			one(OP_WRITE_ENABLE_CMD);
			sfspi_host_i.sel();
			sfspi_host_i.xbyte(OP_RDSR, q);
			sfspi_host_i.xbyte(8'hFF, q);
			chk(oe, 1'h1);
			chk(q, 8'h01 << SR_WEL);
			sfspi_host_i.desel();
			chk(oe, 1'h0);
			one(OP_WRDI);
		end
		wb_io(1'h0, WB_STATUS, 32'h0, d);
		chk(d[8], 1'h1);
		$display("Test modes done");
		// Hold masks an instruction and floats the output
		sfspi_host_i.sel();
		sfspi_host_i.hold(1'h0);
		sfspi_host_i.xbyte(OP_WRITE_ENABLE_CMD, q);
		sfspi_host_i.hold(1'h1);
		sfspi_host_i.xbyte(OP_RDSR, q);
		sfspi_host_i.xbyte(8'hFF, q);
		chk(q, 8'h00);
		sfspi_host_i.hold(1'h0);
		chk(oe, 1'h0);
		sfspi_host_i.hold(1'h1);
		sfspi_host_i.desel();
		$display("Test hold done");
		// Sector erase, then two programs to one byte
		a = 20'($random(seed));
		a[7] = 1'h0;
		one(OP_WRITE_ENABLE_CMD);
		opa(OP_SE, {4'($random(seed)), a});
		sfspi_host_i.desel();
		wb_io(1'h0, WB_STATUS, 32'h0, d);
		chk(d[SR_WIP], 1'h1);
		wait_idle();
		wb_io(1'h0, WB_ADDR, 32'h0, d);
		chk(d, {12'h0, a});
		rd1(a & 20'hFF000, q);
		chk(q, 8'hFF);
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		pp(a, d1);
		pp(a, d2);
		rd1(a, q);
		chk(q, prog(d1, d2));
		rd1(a + 20'h1, q);
		chk(q, 8'hFF);
		$display("Test program done");
		// Lock bit guards the array
		wb_io(1'h1, WB_CTRL, 32'h1, d);
		pp(a + 20'h1, 8'h00);
		rd1(a + 20'h1, q);
		chk(q, 8'hFF);
		wb_io(1'h1, WB_CTRL, 32'h0, d);
		$display("Test lock done");
		// Status lock bit with the write-protect pin
		wrsr(8'h80);
		wb_io(1'h0, WB_STATUS, 32'h0, d);
		chk(d[7:0], 8'h80);
		chk(d[9], wp_n);
		wrsr(8'h1C);
		wb_io(1'h0, WB_STATUS, 32'h0, d);
		chk(d[7:0], wp_n ? 8'h1C : 8'h80);
		$display("Test status lock done");
		finish_test();
	end
endmodule
`default_nettype wire
